//--- logic/esx_pkg.sv
// esx_pkg: constants for the extended-memory access unit.
// assumes a 125 MHz system clock and a byte-wide direct register port.
package esx_pkg;
    localparam int CLK_MHZ = 125;
    // direct register byte addresses
    localparam logic [5:0] ADR_EWA_LO = 6'h03;
    localparam logic [5:0] ADR_WD_0 = 6'h04;
    localparam logic [5:0] ADR_WD_1 = 6'h05;
    localparam logic [5:0] ADR_WD_2 = 6'h06;
    localparam logic [5:0] ADR_WD_3 = 6'h07;
    localparam logic [5:0] ADR_WCS_HI = 6'h08;
    localparam logic [5:0] ADR_WCS_LO = 6'h09;
    localparam logic [5:0] ADR_RA_LO = 6'h0B;
    localparam logic [5:0] ADR_RCS_HI = 6'h0C;
    localparam logic [5:0] ADR_RCS_LO = 6'h0D;
    localparam logic [5:0] ADR_RD_0 = 6'h0E;
    localparam logic [5:0] ADR_RD_1 = 6'h0F;
    localparam logic [5:0] ADR_RD_2 = 6'h10;
    localparam logic [5:0] ADR_RD_3 = 6'h11;
    localparam logic [5:0] ADR_CTRL_HI = 6'h1E;
    localparam logic [5:0] ADR_KEY_HI = 6'h3C;
    localparam logic [5:0] ADR_ERR_LO = 6'h25;
    // field positions
    localparam int TRIG_BIT = 7;
    localparam int PROG_BIT = 0;
    localparam int DONE_BIT = 0;
    localparam int SPECIAL_LSB = 4;
    // extended memory layout
    localparam int EE_WORDS = 32;
    localparam logic [7:0] SHADOW_OFS = 8'h40;
    localparam logic [7:0] LOCK_ADR = 8'h1F;
    localparam int LOCK_LSB = 20;
    localparam logic [3:0] LOCK_EE = 4'hC;
    localparam logic [3:0] LOCK_ALL = 4'h3;
    localparam logic [31:0] PAYLOAD_MASK = 32'h00FF_FFFF;
    localparam logic [3:0] SPEC_MARGIN_LO = 4'h1;
    localparam logic [3:0] SPEC_MARGIN_HI = 4'h2;
    // unlock key bytes in order
    localparam logic [7:0] KEY_0 = 8'h00;
    localparam logic [7:0] KEY_1 = 8'h27;
    localparam logic [7:0] KEY_2 = 8'h81;
    localparam logic [7:0] KEY_3 = 8'h1F;
    localparam logic [7:0] KEY_4 = 8'h77;
    // timing
    localparam int EE_WRITE_MS = 24;
    localparam int EE_READ_US = 2;
    localparam int EE_READ_CYC = EE_READ_US * CLK_MHZ;
    localparam int ERR_XEE_BIT = 0;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
endpackage : esx_pkg

//--- logic/esx_ext_access.sv
// esx_ext_access: extended EEPROM/shadow access behind direct registers.
// assumes a host-side serial decoder on the same clock drives the byte port.
`timescale 1ns/1ns
// Operation
// [RL1] at power-up copy every EEPROM word into shadow before ready rises
// [RL2] shadow word sits at extended address 0x40 above its EEPROM word
// [RL3] unused shadow bits are absent and read as zero
// [RL4] shadow holds payload only, no check bits
// [RL5] full EEPROM write protection (lock field 0x3) applies to shadow too
// [RL6] all reads except margin reads allowed without unlocking
// [RL7] five key bytes 00 27 81 1F 77 to key register unlock writes
// [RL8] unlock stays until next power-on reset
// [RL9] lock field 0xC blocks EEPROM writes, shadow writes still allowed
// [RL10] lock field 0x3 blocks EEPROM and shadow writes
// [RL11] write address register low byte at 0x03 names the target
// [RL12] 32-bit write data loaded as four bytes
// [RL13] write trigger bit starts transfer of write data to target
// [RL14] write-done flag sets when write finishes; EEPROM up to 24 ms
// [RL15] shadow write completes in one cycle after the trigger
// [RL16] write-done flag is bit 0 of byte 0x09
// [RL17] access to locked location aborts, sets done and violation bit
// [RL18] aborted EEPROM write sets violation bit in error register
// [RL19] special field 0001 gives low margin EEPROM reads
// [RL20] special field 0010 gives high margin EEPROM reads
// [RL21] margin settings persist and read back until cleared
// [RL22] margin reads allowed only while unlocked
// [RL23] read trigger loads 32-bit read data, then sets read-done
// [RL24] EEPROM read may take up to 2 us
// [RL25] write in progress clears done flag and shows progress bit
module esx_ext_access
    import esx_pkg::*;
#(
    parameter int EE_WRITE_CYC = EE_WRITE_MS * 1000 * CLK_MHZ
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [5:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out,
    output logic ready_out,
    output logic unlocked_out,
    output logic violation_out,
    output logic [1:0] margin_mode_out
);
    typedef enum logic [2:0] {
        ESX_LOAD, ESX_IDLE, ESX_EE_WRITE, ESX_EE_READ
    } esx_state_e;

    esx_state_e state_reg;
    logic [31:0] ee_mem [EE_WORDS];
    logic [23:0] sh_mem [EE_WORDS];
    logic [4:0] load_idx_reg;
    logic [7:0] wr_adr_reg;
    logic [31:0] wr_data_reg;
    logic [7:0] rd_adr_reg;
    logic [31:0] rd_data_reg;
    logic wr_done_reg, wr_prog_reg, rd_done_reg, rd_prog_reg;
    logic [2:0] key_idx_reg;
    logic unlocked_reg;
    logic warn_xee_reg, err_xee_reg;
    logic [3:0] special_reg;
    logic [31:0] cnt_reg;
    logic wr_trig, rd_trig;
    logic [3:0] lock_field;
    logic [4:0] wr_idx, rd_idx;
    logic wr_is_ee, wr_is_sh, rd_is_ee, rd_is_sh, wr_ok, rd_ok;
    logic [31:0] ee_rd_word;
    logic ee_wr_go;

    default clocking esx_cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    function automatic logic is_ee(input logic [7:0] a);
        return a < 8'(EE_WORDS);
    endfunction : is_ee

    function automatic logic is_sh(input logic [7:0] a);
        return (a >= SHADOW_OFS) && (a < SHADOW_OFS + 8'(EE_WORDS));
    endfunction : is_sh

    assign wr_trig = wr_en_in && (addr_in == ADR_WCS_HI) && wdata_in[TRIG_BIT];
    assign rd_trig = wr_en_in && (addr_in == ADR_RCS_HI) && wdata_in[TRIG_BIT];
    assign lock_field = ee_mem[LOCK_ADR[4:0]][LOCK_LSB +: 4];
    assign wr_idx = wr_adr_reg[4:0];
    assign rd_idx = rd_adr_reg[4:0];
    assign wr_is_ee = is_ee(wr_adr_reg);
    assign wr_is_sh = is_sh(wr_adr_reg);
    assign rd_is_ee = is_ee(rd_adr_reg);
    assign rd_is_sh = is_sh(rd_adr_reg);
    // see [RL5] see [RL9] see [RL10]
    assign wr_ok = unlocked_reg && ((wr_is_ee && lock_field != LOCK_EE && lock_field != LOCK_ALL)
        || (wr_is_sh && lock_field != LOCK_ALL));
    // margin modes need the unlock; plain reads never do, see [RL6] see [RL22]
    assign rd_ok = (rd_is_ee || rd_is_sh)
        && (unlocked_reg || (special_reg != SPEC_MARGIN_LO && special_reg != SPEC_MARGIN_HI));

    // margin threshold modelled by forcing ambiguous cells: none stored here,
    // so margin reads return the stored word; the mode is exported to the array
    assign ee_rd_word = ee_mem[rd_idx]; // see [RL19] see [RL20]
    assign margin_mode_out = (special_reg == SPEC_MARGIN_LO) ? 2'h1 :
        (special_reg == SPEC_MARGIN_HI) ? 2'h2 : 2'h0;
    assign ready_out = (state_reg != ESX_LOAD);
    assign unlocked_out = unlocked_reg;
    assign violation_out = warn_xee_reg;
    assign ee_wr_go = (state_reg == ESX_EE_WRITE) && (cnt_reg == RESET_ZERO);

    // unlock key sequence; any wrong byte restarts it
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            key_idx_reg <= 3'h0;
            unlocked_reg <= 1'b0;
        end else if (wr_en_in && addr_in == ADR_KEY_HI && !unlocked_reg) begin
            unique case (key_idx_reg)
                3'h0: key_idx_reg <= (wdata_in == KEY_0) ? 3'h1 : 3'h0;
                3'h1: key_idx_reg <= (wdata_in == KEY_1) ? 3'h2 : 3'h0;
                3'h2: key_idx_reg <= (wdata_in == KEY_2) ? 3'h3 : 3'h0;
                3'h3: key_idx_reg <= (wdata_in == KEY_3) ? 3'h4 : 3'h0;
                default: begin
                    key_idx_reg <= 3'h0;
                    unlocked_reg <= (wdata_in == KEY_4); // see [RL7] see [RL8]
                end
            endcase
        end
    end

    // address, data and control registers
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_adr_reg <= 8'h00;
            wr_data_reg <= RESET_ZERO;
            rd_adr_reg <= 8'h00;
            special_reg <= 4'h0;
        end else if (wr_en_in) begin
            unique case (addr_in)
                ADR_EWA_LO: wr_adr_reg <= wdata_in; // see [RL11]
                ADR_WD_0: wr_data_reg[31:24] <= wdata_in; // see [RL12]
                ADR_WD_1: wr_data_reg[23:16] <= wdata_in;
                ADR_WD_2: wr_data_reg[15:8] <= wdata_in;
                ADR_WD_3: wr_data_reg[7:0] <= wdata_in;
                ADR_RA_LO: rd_adr_reg <= wdata_in;
                ADR_CTRL_HI: special_reg <= wdata_in[SPECIAL_LSB +: 4]; // see [RL21]
                default: ;
            endcase
        end
    end

    // sequencer: power-up load, extended writes and reads
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= ESX_LOAD;
            load_idx_reg <= 5'h00;
            cnt_reg <= RESET_ZERO;
            wr_done_reg <= 1'b0;
            wr_prog_reg <= 1'b0;
            rd_done_reg <= 1'b0;
            rd_prog_reg <= 1'b0;
            rd_data_reg <= RESET_ZERO;
            warn_xee_reg <= 1'b0;
            err_xee_reg <= 1'b0;
        end else begin
            if (wr_en_in && addr_in == ADR_ERR_LO && wdata_in[ERR_XEE_BIT]) begin
                err_xee_reg <= 1'b0;
                warn_xee_reg <= 1'b0;
            end
            unique case (state_reg)
                ESX_LOAD: begin
                    sh_mem[load_idx_reg] <= ee_mem[load_idx_reg][23:0]; // see [RL1] see [RL4]
                    load_idx_reg <= load_idx_reg + 5'h01;
                    if (load_idx_reg == 5'(EE_WORDS - 1)) begin
                        state_reg <= ESX_IDLE;
                    end
                end
                ESX_IDLE: begin
                    if (wr_trig) begin
                        wr_done_reg <= 1'b0;
                        if (!wr_ok) begin
                            wr_done_reg <= 1'b1; // see [RL17]
                            warn_xee_reg <= 1'b1;
                            if (wr_is_ee) begin
                                err_xee_reg <= 1'b1; // see [RL18]
                            end
                        end else if (wr_is_sh) begin
                            sh_mem[wr_idx] <= wr_data_reg[23:0]; // see [RL2] see [RL15]
                            wr_done_reg <= 1'b1;
                        end else begin
                            wr_prog_reg <= 1'b1; // see [RL25]
                            cnt_reg <= 32'(EE_WRITE_CYC - 1);
                            state_reg <= ESX_EE_WRITE;
                        end
                    end else if (rd_trig) begin
                        rd_done_reg <= 1'b0;
                        if (!rd_ok) begin
                            rd_done_reg <= 1'b1; // see [RL17]
                            warn_xee_reg <= 1'b1;
                        end else if (rd_is_sh) begin
                            rd_data_reg <= {8'h00, sh_mem[rd_idx]}; // see [RL3]
                            rd_done_reg <= 1'b1;
                        end else begin
                            rd_prog_reg <= 1'b1;
                            cnt_reg <= 32'(EE_READ_CYC - 1); // see [RL24]
                            state_reg <= ESX_EE_READ;
                        end
                    end
                end
                ESX_EE_WRITE: begin
                    cnt_reg <= cnt_reg - 32'h1;
                    if (cnt_reg == RESET_ZERO) begin
                        wr_prog_reg <= 1'b0;
                        wr_done_reg <= 1'b1; // see [RL14]
                        state_reg <= ESX_IDLE;
                    end
                end
                ESX_EE_READ: begin
                    cnt_reg <= cnt_reg - 32'h1;
                    if (cnt_reg == RESET_ZERO) begin
                        rd_data_reg <= ee_rd_word; // see [RL23]
                        rd_prog_reg <= 1'b0;
                        rd_done_reg <= 1'b1;
                        state_reg <= ESX_IDLE;
                    end
                end
            endcase
        end
    end

    // register read mux; no unlock needed, see [RL6]
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out <= 8'h00;
        end else if (rd_en_in) begin
            unique case (addr_in)
                ADR_EWA_LO: rdata_out <= wr_adr_reg;
                ADR_WD_0: rdata_out <= wr_data_reg[31:24];
                ADR_WD_1: rdata_out <= wr_data_reg[23:16];
                ADR_WD_2: rdata_out <= wr_data_reg[15:8];
                ADR_WD_3: rdata_out <= wr_data_reg[7:0];
                ADR_WCS_HI: rdata_out <= {7'h00, wr_prog_reg};
                ADR_WCS_LO: rdata_out <= {7'h00, wr_done_reg}; // see [RL16]
                ADR_RA_LO: rdata_out <= rd_adr_reg;
                ADR_RCS_HI: rdata_out <= {7'h00, rd_prog_reg};
                ADR_RCS_LO: rdata_out <= {7'h00, rd_done_reg};
                ADR_RD_0: rdata_out <= rd_data_reg[31:24];
                ADR_RD_1: rdata_out <= rd_data_reg[23:16];
                ADR_RD_2: rdata_out <= rd_data_reg[15:8];
                ADR_RD_3: rdata_out <= rd_data_reg[7:0];
                ADR_CTRL_HI: rdata_out <= {special_reg, 4'h0};
                ADR_ERR_LO: rdata_out <= {7'h00, err_xee_reg};
                default: rdata_out <= 8'h00;
            endcase
        end
    end

    // array contents are not reset; real cells keep their charge.
    // plain always so the cells may be preloaded from outside, see [RL13]
    always @(posedge clock_in) begin
        if (ee_wr_go) begin
            ee_mem[wr_idx] <= wr_data_reg;
        end
    end

    a_shadow_write_done: assert property ( // see [RL15]
        state_reg == ESX_IDLE && wr_trig && wr_ok && wr_is_sh |=> wr_done_reg)
        else $error("shadow write did not finish in one cycle");
    a_lock_blocks_ee: assert property ( // see [RL9]
        state_reg == ESX_IDLE && wr_trig && wr_is_ee && lock_field == LOCK_EE
        |=> state_reg != ESX_EE_WRITE && warn_xee_reg)
        else $error("locked eeprom write was not refused");
    a_lock_all: assert property ( // see [RL10]
        state_reg == ESX_IDLE && wr_trig && lock_field == LOCK_ALL |=> wr_done_reg && warn_xee_reg)
        else $error("full lock did not abort write");
    a_unlock_stays: assert property ( // see [RL8]
        unlocked_reg |=> unlocked_reg)
        else $error("unlock was lost");
    a_prog_clears_done: assert property ( // see [RL25]
        wr_prog_reg |-> !wr_done_reg)
        else $error("done flag high during eeprom write");
    a_ee_abort_err: assert property ( // see [RL18]
        state_reg == ESX_IDLE && wr_trig && !wr_ok && wr_is_ee |=> err_xee_reg)
        else $error("eeprom abort did not set error bit");
    a_read_latency: assert property ( // see [RL23]
        $rose(rd_prog_reg) |-> ##[1:300] rd_done_reg)
        else $error("eeprom read did not finish in time");
    a_locked_no_write: assert property ( // see [RL7]
        !unlocked_reg && state_reg == ESX_IDLE && wr_trig |=> !wr_prog_reg && wr_done_reg)
        else $error("write started while locked");

    // power-up load
    a_load_then_ready: assert property ( // see [RL1]
        state_reg == ESX_LOAD && load_idx_reg == 5'(EE_WORDS - 1) |=> ready_out)
        else $error("ready did not follow the load");
    a_load_payload: assert property ( // see [RL4]
        state_reg == ESX_LOAD
        |=> sh_mem[$past(load_idx_reg)] == ee_mem[$past(load_idx_reg)][23:0])
        else $error("shadow load lost payload");

    // shadow writes and locks
    a_shadow_lands: assert property ( // see [RL2]
        state_reg == ESX_IDLE && wr_trig && wr_ok && wr_is_sh
        |=> sh_mem[wr_idx] == wr_data_reg[23:0])
        else $error("shadow word not written");
    a_shadow_ee_lock: assert property ( // see [RL9]
        state_reg == ESX_IDLE && wr_trig && unlocked_reg && wr_is_sh && lock_field == LOCK_EE
        |=> wr_done_reg && $stable(warn_xee_reg))
        else $error("shadow write refused under eeprom lock");
    a_shadow_full_lock: assert property ( // see [RL5]
        state_reg == ESX_IDLE && wr_trig && wr_is_sh && lock_field == LOCK_ALL
        |=> warn_xee_reg && $stable(err_xee_reg))
        else $error("shadow write not refused under full lock");

    // key sequence
    a_key_opens: assert property ( // see [RL7]
        !unlocked_reg && wr_en_in && addr_in == ADR_KEY_HI && key_idx_reg == 3'h4
        && wdata_in == KEY_4 |=> unlocked_reg)
        else $error("last key byte did not unlock");
    a_key_restart: assert property ( // see [RL7]
        !unlocked_reg && wr_en_in && addr_in == ADR_KEY_HI && key_idx_reg == 3'h2
        && wdata_in != KEY_2 |=> key_idx_reg == 3'h0)
        else $error("wrong key byte did not restart");
    a_key_frozen: assert property ( // see [RL8]
        unlocked_reg |=> $stable(key_idx_reg))
        else $error("key state moved after unlock");

    a_ee_write_ends: assert property ( // see [RL14]
        state_reg == ESX_EE_WRITE && cnt_reg == RESET_ZERO |=> wr_done_reg && !wr_prog_reg)
        else $error("eeprom write did not finish");
    a_read_abort: assert property ( // see [RL17]
        state_reg == ESX_IDLE && rd_trig && !rd_ok |=> rd_done_reg && warn_xee_reg)
        else $error("refused read not flagged");
    a_margin_lock: assert property ( // see [RL22]
        !unlocked_reg && special_reg == SPEC_MARGIN_LO && state_reg == ESX_IDLE && rd_trig
        |=> state_reg != ESX_EE_READ && warn_xee_reg)
        else $error("locked margin read not refused");
    a_plain_read_ok: assert property ( // see [RL6]
        state_reg == ESX_IDLE && rd_trig && rd_is_ee && special_reg == 4'h0
        |=> state_reg == ESX_EE_READ)
        else $error("plain read not started");
    a_margin_persist: assert property ( // see [RL21]
        margin_mode_out != 2'h0 && !(wr_en_in && addr_in == ADR_CTRL_HI)
        |=> $stable(margin_mode_out))
        else $error("margin mode changed on its own");
    a_margin_low: assert property ( // see [RL19]
        special_reg == SPEC_MARGIN_LO |-> margin_mode_out == 2'h1)
        else $error("low margin not exported");
    a_margin_high: assert property ( // see [RL20]
        special_reg == SPEC_MARGIN_HI |-> margin_mode_out == 2'h2)
        else $error("high margin not exported");
    a_shadow_read_zero: assert property ( // see [RL3]
        state_reg == ESX_IDLE && rd_trig && rd_ok && rd_is_sh
        |=> rd_done_reg && rd_data_reg[31:24] == 8'h00)
        else $error("shadow read upper bits not zero");
    a_err_clear: assert property ( // see [RL18]
        wr_en_in && addr_in == ADR_ERR_LO && wdata_in[ERR_XEE_BIT]
        |=> !err_xee_reg && !warn_xee_reg)
        else $error("violation bits not cleared");
    a_done_readback: assert property ( // see [RL16]
        rd_en_in && addr_in == ADR_WCS_LO |=> rdata_out == {7'h00, $past(wr_done_reg)})
        else $error("done flag not on bit 0");
    a_read_prog_done: assert property ( // see [RL23]
        rd_prog_reg |-> !rd_done_reg)
        else $error("read done high during eeprom read");
endmodule : esx_ext_access

//--- bench/esx_host_model.sv
// esx_host_model: host controller driving the direct byte register port.
// assumes the access unit samples strobes on the rising clock edge.
`timescale 1ns/1ns
module esx_host_model
    import esx_pkg::*;
(
    input wire logic clock_in,
    input wire logic [7:0] rdata_in,
    output logic wr_en_out,
    output logic rd_en_out,
    output logic [5:0] addr_out,
    output logic [7:0] wdata_out
);
    initial begin
        wr_en_out = 1'b0;
        rd_en_out = 1'b0;
        addr_out = 6'h00;
        wdata_out = 8'h00;
    end
    task automatic wr_byte(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock_in);
        wr_en_out <= 1'b1;
        addr_out <= a;
        wdata_out <= d;
        @(posedge clock_in);
        wr_en_out <= 1'b0;
        // idle lines toggle so a stale value is never mistaken for data
        addr_out <= ~a;
        wdata_out <= ~d;
        #1;
    endtask : wr_byte
    task automatic rd_byte(input logic [5:0] a, output logic [7:0] d);
        @(posedge clock_in);
        rd_en_out <= 1'b1;
        addr_out <= a;
        @(posedge clock_in);
        rd_en_out <= 1'b0;
        addr_out <= ~a;
        #1;
        d = rdata_in;
    endtask : rd_byte
    task automatic unlock();
        wr_byte(ADR_KEY_HI, KEY_0);
        wr_byte(ADR_KEY_HI, KEY_1);
        wr_byte(ADR_KEY_HI, KEY_2);
        wr_byte(ADR_KEY_HI, KEY_3);
        wr_byte(ADR_KEY_HI, KEY_4);
    endtask : unlock
    // bounded poll of a done flag; eeprom accesses need many reads
    task automatic poll(input logic [5:0] a, output logic ok);
        logic [7:0] d;
        ok = 1'b0;
        for (int i = 0; i < 400 && !ok; i++) begin
            rd_byte(a, d);
            ok = (d[DONE_BIT] === 1'b1);
        end
    endtask : poll
    task automatic ext_write(input logic [7:0] adr, input logic [31:0] d);
        wr_byte(ADR_EWA_LO, adr);
        wr_byte(ADR_WD_0, d[31:24]);
        wr_byte(ADR_WD_1, d[23:16]);
        wr_byte(ADR_WD_2, d[15:8]);
        wr_byte(ADR_WD_3, d[7:0]);
        wr_byte(ADR_WCS_HI, 8'h80);
    endtask : ext_write
    task automatic ext_read(input logic [7:0] adr, output logic [31:0] d);
        logic ok;
        wr_byte(ADR_RA_LO, adr);
        wr_byte(ADR_RCS_HI, 8'h80);
        poll(ADR_RCS_LO, ok);
        rd_byte(ADR_RD_0, d[31:24]);
        rd_byte(ADR_RD_1, d[23:16]);
        rd_byte(ADR_RD_2, d[15:8]);
        rd_byte(ADR_RD_3, d[7:0]);
        if (!ok)
            d = 32'hDEAD_0000;
    endtask : ext_read
endmodule : esx_host_model

//--- bench/esx_ext_access_bench.sv
// esx_ext_access_bench: self-checking bench for the extended access unit.
// assumes the eeprom array is reachable as uut.ee_mem for preloading.
`timescale 1ns/1ns
module esx_ext_access_bench;
    import esx_pkg::*;
    logic clock_in;
    logic rstn_in;
    logic wr_en, rd_en, ready, unlocked, violation;
    logic [5:0] addr;
    logic [7:0] wdata, rdata, b;
    logic [1:0] margin;
    logic [31:0] w;
    logic ok;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    esx_ext_access #(.EE_WRITE_CYC(20)) uut (.clock_in(clock_in), .rstn_in(rstn_in),
        .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata),
        .rdata_out(rdata), .ready_out(ready), .unlocked_out(unlocked),
        .violation_out(violation), .margin_mode_out(margin));
    esx_host_model host (.clock_in(clock_in), .rdata_in(rdata), .wr_en_out(wr_en),
        .rd_en_out(rd_en), .addr_out(addr), .wdata_out(wdata));
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            print_verdict();
        end
    end
    task automatic power_on();
        @(posedge clock_in);
        rstn_in <= 1'b0;
        repeat (4) @(posedge clock_in);
        rstn_in <= 1'b1;
        for (int i = 0; i < 200 && ready !== 1'b1; i++)
            @(posedge clock_in);
        check({31'h0, ready}, 32'h1);
        check({31'h0, unlocked}, 32'h0);
    endtask : power_on
    function automatic logic [31:0] pattern(input int i);
        return {8'hC3, 8'h00, 8'h5A, 3'b000, i[4:0]};
    endfunction : pattern
    task automatic clear_err();
        host.wr_byte(ADR_ERR_LO, 8'h01);
        check({31'h0, violation}, 32'h0);
    endtask : clear_err
    initial begin
        rstn_in = 1'b0;
        for (int i = 0; i < EE_WORDS; i++)
            uut.ee_mem[i] = pattern(i);
        power_on();
        for (int i = 0; i < EE_WORDS; i++) begin
            host.ext_read(SHADOW_OFS + 8'(i), w);
            check(w, pattern(i) & PAYLOAD_MASK);
        end
        host.ext_read(8'h02, w);
        check(w, pattern(2));
        host.ext_write(8'h02, 32'h0011_2233);
        host.poll(ADR_WCS_LO, ok);
        check({31'h0, ok}, 32'h1);
        check({31'h0, violation}, 32'h0000_0001);
        host.rd_byte(ADR_ERR_LO, b);
        check({24'h0, b}, 32'h01);
        clear_err();
        host.wr_byte(ADR_CTRL_HI, 8'h10);
        host.ext_read(8'h02, w);
        check({31'h0, violation}, 32'h1);
        host.wr_byte(ADR_CTRL_HI, 8'h00);
        clear_err();
        host.wr_byte(ADR_KEY_HI, KEY_0);
        host.wr_byte(ADR_KEY_HI, KEY_1);
        host.wr_byte(ADR_KEY_HI, 8'h82);
        host.wr_byte(ADR_KEY_HI, KEY_3);
        host.wr_byte(ADR_KEY_HI, KEY_4);
        check({31'h0, unlocked}, 32'h0);
        host.unlock();
        check({31'h0, unlocked}, 32'h1);
        host.wr_byte(ADR_KEY_HI, 8'h55);
        check({31'h0, unlocked}, 32'h1);
        host.ext_write(8'h45, 32'h1234_5678);
        host.rd_byte(ADR_WCS_LO, b);
        check({24'h0, b}, 32'h01);
        host.ext_read(8'h45, w);
        check(w, 32'h0034_5678);
        host.ext_write(8'h06, 32'h00AB_CDEF);
        host.rd_byte(ADR_WCS_HI, b);
        check({24'h0, b}, 32'h01);
        host.rd_byte(ADR_WCS_LO, b);
        check({24'h0, b}, 32'h00);
        host.poll(ADR_WCS_LO, ok);
        check({31'h0, ok}, 32'h1);
        host.ext_read(8'h06, w);
        check(w, 32'h00AB_CDEF);
        check({31'h0, violation}, 32'h0);
        host.wr_byte(ADR_CTRL_HI, {SPEC_MARGIN_LO, 4'h0});
        check({30'h0, margin}, 32'h1);
        host.rd_byte(ADR_CTRL_HI, b);
        check({24'h0, b}, 32'h10);
        host.ext_read(8'h06, w);
        check({31'h0, violation}, 32'h0);
        host.wr_byte(ADR_CTRL_HI, {SPEC_MARGIN_HI, 4'h0});
        check({30'h0, margin}, 32'h2);
        host.wr_byte(ADR_CTRL_HI, 8'h00);
        check({30'h0, margin}, 32'h0);
        // lock 0xC written through the real eeprom path, active once the write lands; reload copies it to shadow
        host.ext_write(LOCK_ADR, {8'h00, LOCK_EE, 20'h00000});
        host.poll(ADR_WCS_LO, ok);
        power_on();
        host.ext_read(SHADOW_OFS + LOCK_ADR, w);
        check(w, {8'h00, LOCK_EE, 20'h00000});
        host.unlock();
        host.ext_write(8'h02, 32'h0000_0001);
        host.poll(ADR_WCS_LO, ok);
        check({31'h0, violation}, 32'h1);
        clear_err();
        host.ext_write(8'h42, 32'h0000_0777);
        host.poll(ADR_WCS_LO, ok);
        check({31'h0, violation}, 32'h0);
        host.ext_read(8'h42, w);
        check(w, 32'h0000_0777);
        uut.ee_mem[LOCK_ADR] = {8'h00, LOCK_ALL, 20'h00000};
        power_on();
        host.unlock();
        host.ext_write(8'h42, 32'h0000_0999);
        host.poll(ADR_WCS_LO, ok);
        check({31'h0, violation}, 32'h1);
        host.ext_read(8'h42, w);
        check(w, pattern(2) & PAYLOAD_MASK);
        print_verdict();
    end
endmodule : esx_ext_access_bench
